// File: src/rail_health_pkg.sv
/*
 * Constants for the rail health status register bank: offsets, field masks and reset values.
 * Assumes the serial control bus front end hands the bank byte-wide register accesses.
 */
package rail_health_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // slot of each status input group in the synchroniser word
    localparam int unsigned INPUT_GROUPS = 5;
    localparam int unsigned GOOD_A_SLOT  = 0;
    localparam int unsigned GOOD_B_SLOT  = 1;
    localparam int unsigned FAULT_A_SLOT = 2;
    localparam int unsigned FAULT_B_SLOT = 3;
    localparam int unsigned HOT_SLOT     = 4;

    localparam logic [ADDR_W-1:0] RAIL_GOOD_STATUS_A_OFS = 8'hb0;
    localparam logic [ADDR_W-1:0] RAIL_GOOD_STATUS_B_OFS = 8'hb1;
    localparam logic [ADDR_W-1:0] RAIL_FAULT_FLAGS_A_OFS = 8'hb2;
    localparam logic [ADDR_W-1:0] RAIL_FAULT_FLAGS_B_OFS = 8'hb3;
    localparam logic [ADDR_W-1:0] THERMAL_HOT_FLAGS_OFS  = 8'hb5;

    // implemented bits per register; all others read zero
    localparam logic [DATA_W-1:0] GOOD_A_MASK  = 8'hbf;
    localparam logic [DATA_W-1:0] GOOD_B_MASK  = 8'h39;
    localparam logic [DATA_W-1:0] FAULT_A_MASK = 8'hbf;
    localparam logic [DATA_W-1:0] FAULT_B_MASK = 8'h19;
    localparam logic [DATA_W-1:0] HOT_MASK     = 8'h1f;

    localparam logic [DATA_W-1:0] REG_RESET    = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
endpackage

// File: src/rail_health_status_regs.sv
/*
 * Status register bank: live power-good bits, sticky fault and over-temperature flags.
 * Every status input group passes a three-stage synchroniser and an agreement filter
 * before it reaches a register; reads answer one cycle after the strobe.
 * Assumes the control bus front end on clk gives one-cycle read and write strobes with an
 * address; comparator and sensor inputs are asynchronous and are synchronised here.
 * clk_en low freezes every flip-flop, the synchroniser included.
 */
`timescale 1ns/1ns
module rail_health_status_regs (
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    input  wire logic                                clk_en,
    input  wire logic                                wr_stb,
    input  wire logic                                rd_stb,
    input  wire logic [rail_health_pkg::ADDR_W-1:0]  addr,
    input  wire logic [rail_health_pkg::DATA_W-1:0]  wr_data,
    input  wire logic [rail_health_pkg::DATA_W-1:0]  good_a_in,
    input  wire logic [rail_health_pkg::DATA_W-1:0]  good_b_in,
    input  wire logic [rail_health_pkg::DATA_W-1:0]  fault_a_in,
    input  wire logic [rail_health_pkg::DATA_W-1:0]  fault_b_in,
    input  wire logic [rail_health_pkg::DATA_W-1:0]  hot_in,
    output logic      [rail_health_pkg::DATA_W-1:0]  rd_data,
    output logic                                     rd_valid
);
    localparam int unsigned NIN = rail_health_pkg::INPUT_GROUPS;
    localparam int unsigned W   = rail_health_pkg::DATA_W;

    // input groups side by side, one slot of W bits each
    wire logic [NIN-1:0][W-1:0] raw;
    wire logic [NIN-1:0][W-1:0] level;

    assign raw[rail_health_pkg::GOOD_A_SLOT]  = good_a_in;
    assign raw[rail_health_pkg::GOOD_B_SLOT]  = good_b_in;
    assign raw[rail_health_pkg::FAULT_A_SLOT] = fault_a_in;
    assign raw[rail_health_pkg::FAULT_B_SLOT] = fault_b_in;
    assign raw[rail_health_pkg::HOT_SLOT]     = hot_in;

    // per group: three-stage synchroniser, then a filter that moves a bit only
    // where stages two and three agree, so a one-cycle glitch never counts
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            logic [W-1:0] s1_q;
            logic [W-1:0] s2_q;
            logic [W-1:0] s3_q;
            logic [W-1:0] agree;
            logic [W-1:0] level_d;
            logic [W-1:0] level_q;

            // stage one may go metastable; only stage two reads it
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_q <= rail_health_pkg::REG_RESET;
                end else if (clk_en) begin
                    s1_q <= raw[gi];
                end
            end

            // stages two and three feed the agreement filter
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s2_q <= rail_health_pkg::REG_RESET;
                    s3_q <= rail_health_pkg::REG_RESET;
                end else if (clk_en) begin
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            always_comb begin
                agree   = ~(s2_q ^ s3_q);
                level_d = (level_q & ~agree) | (s3_q & agree);
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    level_q <= rail_health_pkg::REG_RESET;
                end else if (clk_en) begin
                    level_q <= level_d;
                end
            end

            assign level[gi] = level_q;
        end
    endgenerate

    // write decode: one strobe per writable register; the good registers take none
    logic wr_fa;
    logic wr_fb;
    logic wr_hot;

    always_comb begin
        wr_fa  = wr_stb && (addr == rail_health_pkg::RAIL_FAULT_FLAGS_A_OFS);
        wr_fb  = wr_stb && (addr == rail_health_pkg::RAIL_FAULT_FLAGS_B_OFS);
        wr_hot = wr_stb && (addr == rail_health_pkg::THERMAL_HOT_FLAGS_OFS);
    end

    // clear masks: only 1 bits of an accepted write clear a flag
    logic [W-1:0] clr_fa;
    logic [W-1:0] clr_fb;
    logic [W-1:0] clr_hot;

    // register images as the host reads them
    logic [W-1:0] good_a_d;
    logic [W-1:0] good_a_q;
    logic [W-1:0] good_b_d;
    logic [W-1:0] good_b_q;
    logic [W-1:0] fault_a_d;
    logic [W-1:0] fault_a_q;
    logic [W-1:0] fault_b_d;
    logic [W-1:0] fault_b_q;
    logic [W-1:0] hot_d;
    logic [W-1:0] hot_q;

    // live good bits follow the filtered levels both ways, no latching
    always_comb begin
        good_a_d = level[rail_health_pkg::GOOD_A_SLOT] & rail_health_pkg::GOOD_A_MASK;
        good_b_d = level[rail_health_pkg::GOOD_B_SLOT] & rail_health_pkg::GOOD_B_MASK;
    end

    // a present event re-sets its flag even in the cycle of a clear
    always_comb begin
        clr_fa    = wr_fa ? wr_data : rail_health_pkg::REG_RESET;
        fault_a_d = ((fault_a_q & ~clr_fa) | level[rail_health_pkg::FAULT_A_SLOT])
                    & rail_health_pkg::FAULT_A_MASK;
    end

    always_comb begin
        clr_fb    = wr_fb ? wr_data : rail_health_pkg::REG_RESET;
        fault_b_d = ((fault_b_q & ~clr_fb) | level[rail_health_pkg::FAULT_B_SLOT])
                    & rail_health_pkg::FAULT_B_MASK;
    end

    // only the five sensor bits exist; the rest read zero
    always_comb begin
        clr_hot = wr_hot ? wr_data : rail_health_pkg::REG_RESET;
        hot_d   = ((hot_q & ~clr_hot) | level[rail_health_pkg::HOT_SLOT])
                  & rail_health_pkg::HOT_MASK;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            good_a_q <= rail_health_pkg::REG_RESET;
        end else if (clk_en) begin
            good_a_q <= good_a_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            good_b_q <= rail_health_pkg::REG_RESET;
        end else if (clk_en) begin
            good_b_q <= good_b_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_a_q <= rail_health_pkg::REG_RESET;
        end else if (clk_en) begin
            fault_a_q <= fault_a_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_b_q <= rail_health_pkg::REG_RESET;
        end else if (clk_en) begin
            fault_b_q <= fault_b_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hot_q <= rail_health_pkg::REG_RESET;
        end else if (clk_en) begin
            hot_q <= hot_d;
        end
    end

    // read mux: pure selection, nothing changes on a read
    logic [W-1:0] rd_data_d;

    always_comb begin
        unique case (addr)
            rail_health_pkg::RAIL_GOOD_STATUS_A_OFS: rd_data_d = good_a_q;
            rail_health_pkg::RAIL_GOOD_STATUS_B_OFS: rd_data_d = good_b_q;
            rail_health_pkg::RAIL_FAULT_FLAGS_A_OFS: rd_data_d = fault_a_q;
            rail_health_pkg::RAIL_FAULT_FLAGS_B_OFS: rd_data_d = fault_b_q;
            rail_health_pkg::THERMAL_HOT_FLAGS_OFS:  rd_data_d = hot_q;
            default:                                 rd_data_d = rail_health_pkg::READ_UNMAPPED;
        endcase
    end

    // read answer stands for exactly one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= rd_stb;
        end
    end

    // read data holds until the next read is taken
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= rail_health_pkg::REG_RESET;
        end else if (clk_en && rd_stb) begin
            rd_data <= rd_data_d;
        end
    end
endmodule

// File: verif/rail_health_checker.sv
/*
 * Port assertions for the status bank: read answer timing and reserved bits.
 * Assumes it is bound to the bank top and sees only its ports.
 */
`timescale 1ns/1ns
module rail_health_checker (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic       rd_stb,
    input wire logic       rd_valid,
    input wire logic [7:0] addr,
    input wire logic [7:0] rd_data
);
    logic      [7:0] addr_q;
    wire logic [7:0] ra = rd_valid ? addr_q : 8'h00;

    // address of the read that rd_data answers; frozen with the bank
    always_ff @(posedge clk) begin
        if (clk_en) begin
            addr_q <= addr;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    read_answer_a: assert property (rd_stb && clk_en |=> rd_valid) else $error("late");
    read_quiet_a: assert property (clk_en && !rd_stb |=> !rd_valid) else $error("stray");
    good_a_rsvd_a: assert property (ra == 8'hb0 |-> !rd_data[6]) else $error("b0");
    good_b_rsvd_a: assert property (ra == 8'hb1 |-> !(rd_data & 8'hc6)) else $error("b1");
    fault_a_rsvd_a: assert property (ra == 8'hb2 |-> !rd_data[6]) else $error("b2");
    fault_b_rsvd_a: assert property (ra == 8'hb3 |-> !(rd_data & 8'he6)) else $error("b3");
    hot_rsvd_a: assert property (ra == 8'hb5 |-> !rd_data[7:5]) else $error("b5");
    unmapped_a: assert property (ra == 8'hb4 |-> rd_data == 8'h00) else $error("b4");
    cover property (ra == 8'hb0 && rd_data == 8'hbf);
    cover property (ra == 8'hb2 && rd_data == 8'h01);
    cover property (ra == 8'hb5 && rd_data == 8'h1f);
    cover property (!clk_en ##1 clk_en);
endmodule

// File: verif/host_model.sv
/*
 * Host on the strobe port of the status bank: one strobe cycle per transfer.
 * Assumes callers wait for a transfer to return before starting the next.
 */
`timescale 1ns/1ns
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output logic            wr_stb,
    output logic            rd_stb,
    output logic      [7:0] addr,
    output logic      [7:0] wr_data
);
    initial {wr_stb, rd_stb, addr, wr_data} = 18'h0;
    // flags are acknowledged with 1 bits; idle lines show the inverse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk) {wr_stb, rd_stb, addr, wr_data} = {w, !w, a, d};
        @(negedge clk) {wr_stb, rd_stb, addr, wr_data} = {2'b00, ~a, ~d};
        q = rd_data;
    endtask
endmodule

// File: verif/rail_health_status_regs_test.sv
/*
 * Bench for the status bank: scenario tasks drive the status inputs on falling edges
 * and judge every read. Assumes host_model on the strobe port and the bound checker.
 */
`timescale 1ns/1ns
module rail_health_status_regs_test;
    logic       clk         = 1'b0;
    logic       rst_b       = 1'b0;
    logic       clk_en      = 1'b1;
    logic       wr_stb;
    logic       rd_stb;
    logic       rd_valid;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] good_a_in   = 8'h00;
    logic [7:0] good_b_in   = 8'h00;
    logic [7:0] fault_a_in  = 8'h00;
    logic [7:0] fault_b_in  = 8'h00;
    logic [7:0] hot_in      = 8'h00;
    int         miscompares = 0;
    int         cmp_count   = 0;

    always #2 clk = ~clk;

    rail_health_status_regs rail_health_status_regs_i (
        .clk        (clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .wr_stb     (wr_stb),
        .rd_stb     (rd_stb),
        .addr       (addr),
        .wr_data    (wr_data),
        .good_a_in  (good_a_in),
        .good_b_in  (good_b_in),
        .fault_a_in (fault_a_in),
        .fault_b_in (fault_b_in),
        .hot_in     (hot_in),
        .rd_data    (rd_data),
        .rd_valid   (rd_valid)
    );

    host_model host_model_i (
        .clk     (clk),
        .rd_data (rd_data),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb),
        .addr    (addr),
        .wr_data (wr_data)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask

    // one read; data and valid stand in the cycle after the strobe
    task automatic rx(input logic [7:0] a, input logic [7:0] want);
        logic [7:0] q;
        host_model_i.xfer(1'b0, a, 8'h00, q);
        check({7'h00, rd_valid}, 8'h01);
        check(q, want);
    endtask

    task automatic wx(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_model_i.xfer(1'b1, a, d, q);
    endtask

    // new levels, then enough cycles for the synchroniser and filter
    task automatic drive_inputs(input logic [39:0] v);
        {good_a_in, good_b_in, fault_a_in, fault_b_in, hot_in} = v;
        repeat (8) @(negedge clk);
    endtask

    task automatic reset_values;
        for (int i = 0; i < 6; i++) begin
            rx(8'hb0 + 8'(i), 8'h00);
        end
    endtask

    task automatic good_follow;
        drive_inputs('1);
        rx(8'hb0, 8'hbf);
        rx(8'hb1, 8'h39);
        drive_inputs(40'h0000010000);
        rx(8'hb0, 8'h00);
        rx(8'hb1, 8'h00);
    endtask

    task automatic sticky_flags;
        wx(8'hb3, 8'h00);
        rx(8'hb2, 8'hbf);
        rx(8'hb3, 8'h19);
        rx(8'hb5, 8'h1f);
        wx(8'hb5, 8'h01);
        rx(8'hb5, 8'h1e);
        for (int i = 0; i < 6; i++) begin
            wx(8'hb0 + 8'(i), 8'hff);
        end
        rx(8'hb2, 8'h01);
        rx(8'hb3, 8'h00);
        rx(8'hb5, 8'h00);
        rx(8'hb4, 8'h00);
    endtask

    // a write while clk_en is low must not be taken
    task automatic freeze_hold;
        drive_inputs(40'h0000010001);
        drive_inputs(40'h0000010000);
        clk_en = 1'b0;
        wx(8'hb5, 8'hff);
        clk_en = 1'b1;
        rx(8'hb5, 8'h01);
        wx(8'hb5, 8'hff);
        rx(8'hb5, 8'h00);
    endtask

    task automatic mid_reset;
        drive_inputs(40'h00000000ff);
        rx(8'hb5, 8'h1f);
        rst_b = 1'b0;
        {good_a_in, good_b_in, fault_a_in, fault_b_in, hot_in} = '0;
        @(negedge clk);
        check(rd_data, 8'h00);
        check({7'h00, rd_valid}, 8'h00);
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        rx(8'hb5, 8'h00);
        rx(8'hb2, 8'h00);
    endtask

    task automatic report_and_stop;
        $display("%0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        reset_values;
        good_follow;
        sticky_flags;
        freeze_hold;
        mid_reset;
        report_and_stop;
    end

    initial begin
        #4000;
        miscompares++;
        report_and_stop;
    end
endmodule

bind rail_health_status_regs rail_health_checker rail_health_checker_i (
    .clk      (clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .rd_stb   (rd_stb),
    .rd_valid (rd_valid),
    .addr     (addr),
    .rd_data  (rd_data)
);
